//--- crcm_top.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "crcm_regs.svh"
module crcm_top #(
   parameter int NUM_WREG = 16,
   parameter int PC_W = 23,
   parameter int LONG_CYC = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire crcm_pkg::crcm_instr_t fetch_word,
   input wire logic fetch_valid,
   output crcm_pkg::crcm_pc_t fetch_pc,
   output logic fetch_ready,
   output logic exec_busy,
   output crcm_pkg::crcm_ctx_t ctx_status
);
   import crcm_pkg::*;
   // ==========================================================
   // Bus decode
   logic wr_en;
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction
   function automatic logic is_wreg(input logic [11:0] a);
      return a <= `CRCM_WREG_LAST && a[1:0] == 2'b00;
   endfunction
   // Next address of a bit-reversed walk over 2**n words: the word index in
   // bits n:1 counts in reversed bit order. The carry out of the reversed count
   // is dropped so the walk stays inside its buffer; bit 0 and bits above n are
   // kept, so the buffer base must be aligned to its own size.
   function automatic crcm_word_t brev_step(input crcm_word_t a, input logic [3:0] n);
      crcm_word_t r;
      crcm_word_t c;
      r = a;
      c = '0;
      for (int i = 0; i < 15; i++) begin
         if (i < n) begin
            c[i] = a[n - i];
         end
      end
      c = c + 16'h0001;
      for (int i = 0; i < 15; i++) begin
         if (i < n) begin
            r[n - i] = c[i];
         end
      end
      return r;
   endfunction
   // Modulo step: wrap between start and end
   function automatic crcm_word_t modstep(input crcm_word_t a, input crcm_word_t s,
                                          input crcm_word_t e, input logic en);
      if (en && a == e) begin
         return s;
      end
      return a + 16'h0002;
   endfunction
   // ==========================================================
   // Register contexts
   crcm_word_t wreg_ff [0:2][0:NUM_WREG-2];
   crcm_word_t sp_ff;
   crcm_altcfg_t altcfg_ff;
   crcm_ctx_t ctx_ff;
   logic [2:0] ctx_stack_ff [0:`CRCM_NEST-1];
   logic [2:0] depth_ff;
   logic [3:0] widx;
   logic [1:0] cur;
   logic cmd_wr;
   logic [2:0] cmd_ipl;
   logic [2:0] irq_set;
   assign widx = paddr[5:2];
   assign cur = ctx_ff.current_context_id[1:0];
   assign cmd_wr = wr_en && hit(paddr, `CRCM_CMD);
   assign cmd_ipl = pwdata[`CRCM_CMD_IPL_LO +: 3];
   assign ctx_status = ctx_ff;
   always_comb begin
      irq_set = 3'h0;
      if (cmd_ipl != 3'h0 && cmd_ipl != 3'h7) begin
         if (cmd_ipl == altcfg_ff.ipl_alt1) begin
            irq_set = 3'h1;
         end else if (cmd_ipl == altcfg_ff.ipl_alt2) begin
            irq_set = 3'h2;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            for (int i = 0; i < NUM_WREG - 1; i++) begin
               wreg_ff[c][i] <= 16'h0000;
            end
         end
      end else if (wr_en && is_wreg(paddr) && widx != 4'hf) begin
         wreg_ff[cur][widx] <= pwdata[15:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff <= `CRCM_SP_RST;
      end else if (wr_en && hit(paddr, `CRCM_WREG_LAST)) begin
         sp_ff <= {pwdata[15:1], 1'b0};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         altcfg_ff <= '0;
      end else if (wr_en && hit(paddr, `CRCM_ALTCFG)) begin
         altcfg_ff <= pwdata[5:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctx_ff <= '0;
         depth_ff <= 3'h0;
         for (int i = 0; i < `CRCM_NEST; i++) begin
            ctx_stack_ff[i] <= 3'h0;
         end
      end else if (cmd_wr) begin
         if (pwdata[`CRCM_CMD_SWAP]) begin
            if (pwdata[`CRCM_CMD_SET_LO +: 3] <= 3'h2) begin
               ctx_ff.current_context_id <= pwdata[`CRCM_CMD_SET_LO +: 3];
               ctx_ff.manual_context_id <= pwdata[`CRCM_CMD_SET_LO +: 3];
            end
         end else if (pwdata[`CRCM_CMD_IRQ] && depth_ff < 3'(`CRCM_NEST)) begin
            ctx_stack_ff[depth_ff[1:0]] <= ctx_ff.current_context_id;
            depth_ff <= depth_ff + 3'h1;
            if (irq_set != 3'h0) begin
               ctx_ff.current_context_id <= irq_set;
            end
         end else if (pwdata[`CRCM_CMD_RET] && depth_ff != 3'h0) begin
            ctx_ff.current_context_id <= ctx_stack_ff[2'(depth_ff - 3'h1)];
            depth_ff <= depth_ff - 3'h1;
         end
      end
   end
   // ==========================================================
   // Data space pages and window
   logic [9:0] rdpage_ff, wrpage_ff;
   logic [8:0] psvpage_ff;
   logic [15:0] lstartl_ff, lstarth_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdpage_ff <= `CRCM_PAGE_RST;
         wrpage_ff <= `CRCM_PAGE_RST;
         psvpage_ff <= '0;
      end else if (wr_en) begin
         if (hit(paddr, `CRCM_RDPAGE)) begin
            rdpage_ff <= pwdata[9:0];
         end
         if (hit(paddr, `CRCM_WRPAGE)) begin
            wrpage_ff <= pwdata[9:0];
         end
         if (hit(paddr, `CRCM_PSVPAGE)) begin
            psvpage_ff <= pwdata[8:0];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lstartl_ff <= `CRCM_LSTART_RST;
         lstarth_ff <= `CRCM_LSTART_RST;
      end else begin
         lstartl_ff <= lstartl_ff;
         lstarth_ff <= lstarth_ff;
      end
   end
   // ==========================================================
   // Address generators
   crcm_word_t xaddr_ff, yaddr_ff, xs_ff, xe_ff, ys_ff, ye_ff;
   logic [2:0] modcon_ff;
   logic [3:0] brev_ff;
   logic [23:0] eaddr_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xs_ff <= '0;
         xe_ff <= '0;
         ys_ff <= '0;
         ye_ff <= '0;
         modcon_ff <= '0;
         brev_ff <= '0;
      end else if (wr_en) begin
         if (hit(paddr, `CRCM_XMODS)) begin
            xs_ff <= pwdata[15:0];
         end
         if (hit(paddr, `CRCM_XMODE)) begin
            xe_ff <= pwdata[15:0];
         end
         if (hit(paddr, `CRCM_YMODS)) begin
            ys_ff <= pwdata[15:0];
         end
         if (hit(paddr, `CRCM_YMODE)) begin
            ye_ff <= pwdata[15:0];
         end
         if (hit(paddr, `CRCM_MODCON)) begin
            modcon_ff <= pwdata[2:0];
         end
         if (hit(paddr, `CRCM_BREV)) begin
            brev_ff <= pwdata[3:0];
         end
      end
   end
   // AGCMD: bit0 load X from W[sel], bit1 step X, bit2 load Y, bit3 step Y
   // bit4 selects Y for dual operand fetch; sel in bits 11:8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xaddr_ff <= '0;
         yaddr_ff <= '0;
         eaddr_ff <= '0;
      end else if (wr_en && hit(paddr, `CRCM_AGCMD)) begin
         if (pwdata[0]) begin
            xaddr_ff <= (pwdata[11:8] == 4'hf) ? sp_ff : wreg_ff[cur][pwdata[11:8]];
         end else if (pwdata[1]) begin
            if (modcon_ff[2]) begin
               xaddr_ff <= brev_step(xaddr_ff, brev_ff);
            end else begin
               xaddr_ff <= modstep(xaddr_ff, xs_ff, xe_ff, modcon_ff[0]);
            end
         end
         if (pwdata[2] && pwdata[4]) begin
            yaddr_ff <= (pwdata[11:8] == 4'hf) ? sp_ff : wreg_ff[cur][pwdata[11:8]];
         end else if (pwdata[3] && pwdata[4]) begin
            yaddr_ff <= modstep(yaddr_ff, ys_ff, ye_ff, modcon_ff[1]);
         end
         if (xaddr_ff[`CRCM_WINDOW_BIT]) begin
            eaddr_ff <= {psvpage_ff, xaddr_ff[14:0]};
         end else begin
            eaddr_ff <= {pwdata[5] ? wrpage_ff : rdpage_ff, xaddr_ff[14:1]};
         end
      end
   end
   // ==========================================================
   // Fetch and execute
   crcm_state_t st_ff;
   logic [1:0] cnt_ff;
   crcm_pc_t pc_ff;
   crcm_instr_t ireg_ff;
   crcm_mode_t mode_ff;
   assign fetch_pc = pc_ff;
   assign fetch_ready = (st_ff == CRCM_S_IDLE);
   assign exec_busy = (st_ff != CRCM_S_IDLE);
   // Top opcode bits pick class; 0x0? flow, 0xe? long, else single cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= CRCM_S_IDLE;
         cnt_ff <= '0;
         pc_ff <= '0;
         ireg_ff <= '0;
         mode_ff <= CRCM_M_INHERENT;
      end else begin
         case (st_ff)
            CRCM_S_IDLE: begin
               if (fetch_valid) begin
                  ireg_ff <= fetch_word;
                  pc_ff <= pc_ff + 23'h2;
                  case (fetch_word[21:19])
                     3'h1: mode_ff <= CRCM_M_RELATIVE;
                     3'h2: mode_ff <= CRCM_M_LITERAL;
                     3'h3: mode_ff <= CRCM_M_MEMDIR;
                     3'h4: mode_ff <= CRCM_M_REGDIR;
                     3'h5: mode_ff <= CRCM_M_REGIND;
                     default: mode_ff <= CRCM_M_INHERENT;
                  endcase
                  if (fetch_word[23:20] == 4'h0) begin
                     st_ff <= CRCM_S_FLOW;
                     pc_ff <= pc_ff + {{7{fetch_word[15]}}, fetch_word[15:0]};
                     cnt_ff <= 2'(LONG_CYC - 1);
                  end else if (fetch_word[23:20] == 4'he) begin
                     st_ff <= CRCM_S_LONG;
                     cnt_ff <= 2'(LONG_CYC - 1);
                  end
               end
            end
            CRCM_S_FLOW, CRCM_S_LONG: begin
               if (cnt_ff == 2'h0 || cmd_wr) begin
                  st_ff <= CRCM_S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 2'h1;
               end
            end
            default: st_ff <= CRCM_S_IDLE;
         endcase
      end
   end
   // ==========================================================
   // Read mux, registered data
   crcm_word_t rdata;
   logic bad;
   always_comb begin
      rdata = 16'h0000;
      bad = 1'b0;
      if (is_wreg(paddr)) begin
         rdata = (widx == 4'hf) ? sp_ff : wreg_ff[cur][widx];
      end else begin
         case (paddr)
            `CRCM_PC: rdata = pc_ff[15:0];
            `CRCM_RDPAGE: rdata = {6'h00, rdpage_ff};
            `CRCM_WRPAGE: rdata = {6'h00, wrpage_ff};
            `CRCM_PSVPAGE: rdata = {7'h00, psvpage_ff};
            `CRCM_ALTCFG: rdata = {10'h000, altcfg_ff};
            `CRCM_CTXSTAT: rdata = {10'h000, ctx_ff};
            `CRCM_CMD: rdata = {13'h0000, depth_ff};
            `CRCM_LSTARTL: rdata = lstartl_ff;
            `CRCM_LSTARTH: rdata = lstarth_ff;
            `CRCM_XMODS: rdata = xs_ff;
            `CRCM_XMODE: rdata = xe_ff;
            `CRCM_YMODS: rdata = ys_ff;
            `CRCM_YMODE: rdata = ye_ff;
            `CRCM_MODCON: rdata = {13'h0000, modcon_ff};
            `CRCM_BREV: rdata = {12'h000, brev_ff};
            `CRCM_AGCMD: rdata = 16'h0000;
            `CRCM_XADDR: rdata = xaddr_ff;
            `CRCM_YADDR: rdata = yaddr_ff;
            `CRCM_EADDR: rdata = eaddr_ff[15:0];
            `CRCM_IREG: rdata = ireg_ff[15:0];
            `CRCM_IINFO: rdata = {mode_ff, 2'h0, ireg_ff[23:16]};
            default: bad = 1'b1;
         endcase
      end
   end
   // Upper bits of PC and extended address ride in the high half
   // Loaded in the setup cycle so the data stands at the zero-wait access edge;
   // a value that moves during the access cycle therefore reads one cycle old
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {9'h000, (hit(paddr, `CRCM_PC) ? pc_ff[22:16] :
                    hit(paddr, `CRCM_EADDR) ? eaddr_ff[22:16] : 7'h00), rdata};
      end
   end
   assign pslverr = psel && penable && bad && !is_wreg(paddr);
endmodule

//--- crcm_regs.svh
`ifndef CRCM_REGS_SVH
`define CRCM_REGS_SVH
// ==========================================================
// Register map, byte addresses
`define CRCM_WREG_BASE 12'h000
`define CRCM_WREG_LAST 12'h03c
`define CRCM_PC 12'h040
`define CRCM_RDPAGE 12'h044
`define CRCM_WRPAGE 12'h048
`define CRCM_PSVPAGE 12'h04c
`define CRCM_ALTCFG 12'h050
`define CRCM_CTXSTAT 12'h054
`define CRCM_CMD 12'h058
`define CRCM_LSTARTL 12'h05c
`define CRCM_LSTARTH 12'h060
`define CRCM_XMODS 12'h064
`define CRCM_XMODE 12'h068
`define CRCM_YMODS 12'h06c
`define CRCM_YMODE 12'h070
`define CRCM_MODCON 12'h074
`define CRCM_BREV 12'h078
`define CRCM_AGCMD 12'h07c
`define CRCM_XADDR 12'h080
`define CRCM_YADDR 12'h084
`define CRCM_EADDR 12'h088
`define CRCM_IREG 12'h08c
`define CRCM_IINFO 12'h090
// ==========================================================
// Command word fields
`define CRCM_CMD_SWAP 0
`define CRCM_CMD_IRQ 1
`define CRCM_CMD_RET 2
`define CRCM_CMD_IPL_LO 4
`define CRCM_CMD_SET_LO 8
// Reset values and sizes
`define CRCM_SP_RST 16'h1000
`define CRCM_LSTART_RST 16'h0000
`define CRCM_WINDOW_BIT 15
`define CRCM_PAGE_RST 10'h001
`define CRCM_NEST 4
`endif

//--- crcm_pkg.sv
package crcm_pkg;
   typedef logic [15:0] crcm_word_t;
   typedef logic [22:0] crcm_pc_t;
   typedef logic [23:0] crcm_instr_t;
   typedef struct packed {
      logic [2:0] ipl_alt2;
      logic [2:0] ipl_alt1;
   } crcm_altcfg_t;
   typedef struct packed {
      logic [2:0] manual_context_id;
      logic [2:0] current_context_id;
   } crcm_ctx_t;
   typedef enum logic [5:0] {
      CRCM_M_INHERENT = 6'h01,
      CRCM_M_RELATIVE = 6'h02,
      CRCM_M_LITERAL = 6'h04,
      CRCM_M_MEMDIR = 6'h08,
      CRCM_M_REGDIR = 6'h10,
      CRCM_M_REGIND = 6'h20
   } crcm_mode_t;
   typedef enum logic [2:0] {
      CRCM_S_IDLE = 3'h1,
      CRCM_S_FLOW = 3'h2,
      CRCM_S_LONG = 3'h4
   } crcm_state_t;
endpackage

//--- crcm_top_properties.sv
`timescale 1ns/1ps
`include "crcm_regs.svh"
module crcm_top_properties #(
   parameter int LONG_CYC = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire crcm_pkg::crcm_instr_t fetch_word,
   input wire logic fetch_valid,
   input wire crcm_pkg::crcm_pc_t fetch_pc,
   input wire logic fetch_ready,
   input wire logic exec_busy,
   input wire crcm_pkg::crcm_ctx_t ctx_status
);
   import crcm_pkg::*;
   logic acc;
   logic cmdw;
   logic take;
   assign acc = psel && penable;
   assign cmdw = acc && pwrite && paddr == `CRCM_CMD;
   assign take = fetch_valid && fetch_ready && !cmdw;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Register bus
   a_unmapped_err: assert property (acc && paddr > 12'h090 |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && paddr <= 12'h090 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_lstart_ro: assert property (acc && !pwrite &&
      (paddr == `CRCM_LSTARTL || paddr == `CRCM_LSTARTH) |-> prdata == 32'h0)
      else $error("loop start register changed");
   a_sp_even: assert property (acc && !pwrite && paddr == `CRCM_WREG_LAST |-> !prdata[0])
      else $error("stack pointer odd");
   // ==========================================================
   // Context selection, only a command write may move it
   a_swap_set: assert property (cmdw && pwdata[2:0] == 3'h1 && pwdata[10:8] <= 3'h2
      |=> ctx_status == {2{$past(pwdata[10:8])}})
      else $error("swap did not select set");
   a_swap_bad: assert property (cmdw && pwdata[2:0] == 3'h1 && pwdata[10:8] > 3'h2
      |=> $stable(ctx_status))
      else $error("invalid swap changed context");
   a_ctx_quiet: assert property (!cmdw |=> $stable(ctx_status))
      else $error("context moved without command");
   // ==========================================================
   // Fetch and execution pacing
   a_single_step: assert property (take && fetch_word[23:20] != 4'h0
      && fetch_word[23:20] != 4'he |=> fetch_pc == $past(fetch_pc) + 23'h2)
      else $error("single instruction step wrong");
   a_flow_busy: assert property (take && fetch_word[23:20] == 4'h0
      |=> exec_busy ##[1:4] !exec_busy)
      else $error("flow change not multi-cycle");
   a_busy_stall: assert property (exec_busy |-> !fetch_ready)
      else $error("fetch open while busy");
endmodule
bind crcm_top crcm_top_properties #(.LONG_CYC(LONG_CYC)) i_crcm_top_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fetch_word(fetch_word), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
   .fetch_ready(fetch_ready), .exec_busy(exec_busy), .ctx_status(ctx_status));

//--- crcm_pmem_model.sv
`timescale 1ns/1ps
module crcm_pmem_model (
   input wire logic go,
   input wire crcm_pkg::crcm_pc_t fetch_pc,
   output crcm_pkg::crcm_instr_t fetch_word,
   output logic fetch_valid
);
   import crcm_pkg::*;
   crcm_instr_t mem [128];
   assign fetch_valid = go;
   // whole instruction words
   // Inverted word while not offered, so a stale sample shows up
   assign fetch_word = go ? mem[fetch_pc[7:1]] : ~mem[fetch_pc[7:1]];
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "crcm_regs.svh"
module testbench;
   import crcm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_ready;
   logic exec_busy, go, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, s, seed, sp;
   crcm_instr_t fetch_word, w, last_w;
   crcm_pc_t fetch_pc, pc_exp;
   crcm_ctx_t ctx_status;
   logic [15:0] v [15];
   logic [15:0] alt [3];
   int err_count, compares;
   crcm_top #(.LONG_CYC(2)) i_crcm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
      .fetch_pc(fetch_pc), .fetch_ready(fetch_ready), .exec_busy(exec_busy),
      .ctx_status(ctx_status));
   crcm_pmem_model i_crcm_pmem_model (.go(go), .fetch_pc(fetch_pc), .fetch_word(fetch_word),
      .fetch_valid(fetch_valid));
   // ==========================================================
   // Expectation helpers
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic crcm_pc_t next_pc(crcm_pc_t pc, crcm_instr_t iw);
      if (iw[23:20] == 4'h0) return pc + {{7{iw[15]}}, iw[15:0]};
      return pc + 23'h2;
   endfunction
   // Extended address as read back: window form if bit 15 is set, else paged form
   function automatic logic [31:0] ea_exp(input logic [15:0] x, input logic [9:0] page);
      logic [23:0] ea;
      ea = x[15] ? {page[8:0], x[14:0]} : {page, x[14:1]};
      return {9'h0, ea[22:0]};
   endfunction
   // Step k of a bit-reversed walk over eight words based at 0x100
   function automatic logic [31:0] brev_exp(input int k);
      logic [2:0] b;
      b = 3'(k);
      return 32'h100 + {28'h0, b[0], b[1], b[2], 1'b0};
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_exp <= '0;
         last_w <= '0;
      end else if (fetch_valid === 1'b1 && fetch_ready === 1'b1) begin
         pc_exp <= next_pc(pc_exp, fetch_word);
         last_w <= fetch_word;
      end
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      // Answer and read data are taken at the access edge itself
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the access edge settle before callers look at outputs
      @(negedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task report_and_stop;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      report_and_stop();
   end
   initial begin
      {presetn, psel, penable, pwrite, go} = '0;
      paddr = '0;
      pwdata = '0;
      err_count = 0;
      compares = 0;
      seed = 32'd11;
      for (int k = 0; k < 128; k++) begin
         s = xs();
         w = s[23:0];
         i_crcm_pmem_model.mem[k] = w;
      end
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`CRCM_WREG_LAST); chk_word(r, 32'h1000);
      rd(`CRCM_RDPAGE); chk_word(r, 32'h1);
      chk_word({26'h0, ctx_status}, 32'h0);
      for (int i = 0; i < 15; i++) begin
         s = xs();
         v[i] = s[15:0];
         wr(12'(4 * i), {16'h0, v[i]});
      end
      for (int i = 0; i < 15; i++) begin
         rd(12'(4 * i)); chk_word(r, {16'h0, v[i]});
      end
      for (int i = 0; i < 3; i++) begin
         s = xs();
         alt[i] = s[15:0];
         wr(`CRCM_CMD, {21'h0, 3'(i), 8'h01});
         chk_word({26'h0, ctx_status}, {26'h0, 3'(i), 3'(i)});
         wr(12'h00c, {16'h0, alt[i]});
         sp = xs();
         wr(`CRCM_WREG_LAST, {16'h0, sp[15:0]});
      end
      for (int i = 0; i < 3; i++) begin
         wr(`CRCM_CMD, {21'h0, 3'(i), 8'h01});
         rd(12'h00c); chk_word(r, {16'h0, alt[i]});
         rd(`CRCM_WREG_LAST); chk_word(r, {16'h0, sp[15:1], 1'b0});
      end
      wr(`CRCM_CMD, 32'h301); chk_word({26'h0, ctx_status}, 32'h12);
      wr(`CRCM_CMD, 32'h001);
      // Set one at priority three, set two at priority five
      wr(`CRCM_ALTCFG, 32'h2b);
      wr(`CRCM_CMD, 32'h52); chk_word({26'h0, ctx_status}, 32'h02);
      wr(`CRCM_CMD, 32'h32); chk_word({26'h0, ctx_status}, 32'h01);
      rd(`CRCM_CMD); chk_word(r, 32'h2);
      rd(12'h00c); chk_word(r, {16'h0, alt[1]});
      wr(`CRCM_CMD, 32'h4); chk_word({26'h0, ctx_status}, 32'h02);
      wr(`CRCM_CMD, 32'h4); chk_word({26'h0, ctx_status}, 32'h00);
      rd(12'h00c); chk_word(r, {16'h0, alt[0]});
      wr(`CRCM_LSTARTL, xs()); rd(`CRCM_LSTARTL); chk_word(r, 32'h0);
      wr(`CRCM_LSTARTH, xs()); rd(`CRCM_LSTARTH); chk_word(r, 32'h0);
      rd(12'h200); chk_flag(e, 1'b1);
      rd(`CRCM_PC); chk_flag(e, 1'b0);
      // Address generators: modulo, window, paged and bit-reversed forms
      wr(`CRCM_MODCON, 32'h3);
      wr(`CRCM_XMODS, 32'h100);
      wr(`CRCM_XMODE, 32'h104);
      wr(`CRCM_YMODS, 32'h100);
      wr(`CRCM_YMODE, 32'h102);
      wr(12'h004, 32'h100);
      wr(12'h008, 32'h8006);
      wr(12'h010, 32'h1234);
      wr(`CRCM_AGCMD, 32'h101);
      rd(`CRCM_XADDR);
      chk_word(r, 32'h100);
      for (int i = 1; i < 4; i++) begin
         wr(`CRCM_AGCMD, 32'h2);
         rd(`CRCM_XADDR);
         chk_word(r, 32'h100 + 32'(2 * (i % 3)));
      end
      s = xs();
      wr(`CRCM_PSVPAGE, {23'h0, s[8:0]});
      wr(`CRCM_WRPAGE, {22'h0, s[18:9]});
      wr(`CRCM_AGCMD, 32'h201);
      wr(`CRCM_AGCMD, 32'h401);
      rd(`CRCM_EADDR);
      chk_word(r, ea_exp(16'h8006, {1'b0, s[8:0]}));
      wr(`CRCM_AGCMD, 32'h20);
      rd(`CRCM_EADDR);
      chk_word(r, ea_exp(16'h1234, s[18:9]));
      wr(`CRCM_AGCMD, 32'h0);
      rd(`CRCM_EADDR);
      chk_word(r, ea_exp(16'h1234, `CRCM_PAGE_RST));
      wr(`CRCM_AGCMD, 32'h114);
      rd(`CRCM_YADDR);
      chk_word(r, 32'h100);
      wr(`CRCM_AGCMD, 32'h20c);
      rd(`CRCM_YADDR);
      chk_word(r, 32'h100);
      for (int i = 1; i < 3; i++) begin
         wr(`CRCM_AGCMD, 32'h18);
         rd(`CRCM_YADDR);
         chk_word(r, 32'h100 + 32'(2 * (i % 2)));
      end
      wr(`CRCM_MODCON, 32'h4);
      wr(`CRCM_BREV, 32'h3);
      wr(`CRCM_AGCMD, 32'h101);
      for (int i = 1; i < 9; i++) begin
         wr(`CRCM_AGCMD, 32'h2);
         rd(`CRCM_XADDR);
         chk_word(r, brev_exp(i));
      end
      // Program memory answers slowly at random
      for (int n = 0; n < 400; n++) begin
         @(posedge pclk);
         s = xs();
         go <= s[0] | s[1];
      end
      @(posedge pclk);
      go <= 1'b0;
      repeat (10) @(posedge pclk);
      chk_word({9'h0, fetch_pc}, {9'h0, pc_exp});
      rd(`CRCM_PC); chk_word(r, {9'h0, pc_exp});
      rd(`CRCM_IREG);
      chk_word(r, {16'h0, last_w[15:0]});
      rd(`CRCM_IINFO);
      chk_word({24'h0, r[7:0]}, {24'h0, last_w[23:16]});
      chk_flag($onehot(r[15:10]), 1'b1);
      report_and_stop();
   end
endmodule
